/* core/frlp_top.sv */
// Flash row latch programmer: registers, key check, latches, commit
//
// Strobed register access and the address map were decided locally.
module frlp_top
(
   // Clock, reset, enable
   input  wire logic                      clk_i,
   input  wire logic                      nrst_i,
   input  wire logic                      ce_i,
   // Register port
   input  wire logic [3:0]                reg_addr_i,
   input  wire logic [7:0]                reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [7:0]                reg_rdata_o,
   // Flash array port
   output frlp_pkg::frlp_flash_req_t      flash_req_o,
   input  wire logic                      flash_ready_i,
   input  wire logic                      write_protect_i,
   // Processor stall
   output logic                           cpu_stall_o
);

   // ---------------------------------------------------------------
   // State record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                     addr_low;   // Address low byte
      logic [7:0]                     addr_high;  // Address high byte
      logic [7:0]                     data_low;   // Data low byte
      logic [7:0]                     data_high;  // Data high byte
      logic                           permit;     // Modify permit
      logic                           llo;        // Latch load only
      logic                           erase;      // Erase select
      logic                           css;        // Config space select
      logic                           fault;      // Program fault flag
      logic                           done;       // Memory done flag
      frlp_pkg::frlp_key_t            key;        // Key progress
      frlp_pkg::frlp_op_t             op;         // Running operation
      logic [frlp_pkg::IDX_W-1:0]     cnt;        // Word counter
      logic [frlp_pkg::ROW_W-1:0]     row;        // Captured row
      logic                           op_css;     // Captured select
      logic [7:0]                     rdata;      // Read data
      // Write latches, blank after every operation
      logic [frlp_pkg::LATCH_COUNT-1:0][frlp_pkg::WORD_W-1:0] latch;
   } frlp_state_t;

   frlp_state_t state_reg;   // Registered state
   frlp_state_t state_next;  // Next state

   // ---------------------------------------------------------------
   // Address decode helpers
   // ---------------------------------------------------------------
   logic [frlp_pkg::ROW_W-1:0] cur_row;   // Row from address pair
   logic [frlp_pkg::IDX_W-1:0] cur_idx;   // Latch from address pair
   logic [frlp_pkg::WORD_W-1:0] cur_word; // Word from data pair
   logic                       wr_ctl;    // Write to control
   logic                       wr_key;    // Write to unlock key
   logic                       any_strobe; // Any bus access
   logic                       trig_ok;   // Key completed by trigger
   logic                       busy;      // Operation running

   assign cur_row  = {state_reg.addr_high[6:0], state_reg.addr_low[7:5]};
   assign cur_idx  = state_reg.addr_low[4:0];
   assign cur_word = {state_reg.data_high[5:0], state_reg.data_low};
   // Strobe decode; the clock enable gates the state update
   assign wr_ctl   = reg_wr_i && (reg_addr_i == frlp_pkg::CONTROL_OFS);
   assign wr_key   = reg_wr_i && (reg_addr_i == frlp_pkg::UNLOCK_OFS);
   assign any_strobe = reg_wr_i || reg_rd_i;
   assign busy     = (state_reg.op != frlp_pkg::OP_IDLE);
   // trigger only counts straight after both keys
   assign trig_ok  = (state_reg.key == frlp_pkg::KEY_ARMED) && wr_ctl &&
                     reg_wdata_i[frlp_pkg::CTL_TRIGGER_BIT];

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      // Everything holds unless changed below
      state_next = state_reg;
      // Bus writes and key steps only count while idle
      if (!busy)
      begin
         // Register writes
         if (reg_wr_i)
         begin
            unique case (reg_addr_i)
               frlp_pkg::ADDR_LOW_OFS:  state_next.addr_low  = reg_wdata_i;
               frlp_pkg::ADDR_HIGH_OFS: state_next.addr_high = reg_wdata_i;
               frlp_pkg::DATA_LOW_OFS:  state_next.data_low  = reg_wdata_i;
               frlp_pkg::DATA_HIGH_OFS: state_next.data_high = reg_wdata_i;
               frlp_pkg::CONTROL_OFS:
               begin
                  state_next.permit = reg_wdata_i[frlp_pkg::CTL_PERMIT_BIT];
                  state_next.llo    = reg_wdata_i[frlp_pkg::CTL_LLO_BIT];
                  state_next.erase  = reg_wdata_i[frlp_pkg::CTL_ERASE_BIT];
                  state_next.css    = reg_wdata_i[frlp_pkg::CTL_CSS_BIT];
                  state_next.fault  = reg_wdata_i[frlp_pkg::CTL_FAULT_BIT];
                  state_next.done   = reg_wdata_i[frlp_pkg::CTL_DONE_BIT];
               end
               default:
               begin
                  // Unlock key and unmapped offsets store nothing
               end
            endcase
         end
         // Key sequence tracking
         unique case (state_reg.key)
            frlp_pkg::KEY_IDLE:
            begin
               // First key byte opens the sequence
               if (wr_key && reg_wdata_i == frlp_pkg::KEY_FIRST)
                  state_next.key = frlp_pkg::KEY_HALF;
            end
            frlp_pkg::KEY_HALF:
            begin
               // Only the second key byte may follow
               if (wr_key && reg_wdata_i == frlp_pkg::KEY_SECOND)
                  state_next.key = frlp_pkg::KEY_ARMED;
               else if (any_strobe)
               begin
                  state_next.key   = frlp_pkg::KEY_IDLE;
                  state_next.fault = 1'b1;
               end
            end
            frlp_pkg::KEY_ARMED:
            begin
               // Any strobe ends the armed state
               if (any_strobe)
                  state_next.key = frlp_pkg::KEY_IDLE;
               if (any_strobe && !trig_ok)
                  state_next.fault = 1'b1;
            end
            default:
               state_next.key = frlp_pkg::KEY_IDLE;
         endcase
         // Trigger accepted with write permission
         // Trigger without permit is dropped, no fault
         // Mode and select come from this very write
         if (trig_ok && reg_wdata_i[frlp_pkg::CTL_PERMIT_BIT])
         begin
            state_next.row    = cur_row;
            state_next.op_css = reg_wdata_i[frlp_pkg::CTL_CSS_BIT];
            state_next.cnt    = '0;
            if (reg_wdata_i[frlp_pkg::CTL_ERASE_BIT])
            begin
               if (write_protect_i)
                  state_next.fault = 1'b1;
               else
                  state_next.op = frlp_pkg::OP_ERASE;
            end
            else if (reg_wdata_i[frlp_pkg::CTL_LLO_BIT])
            begin
               state_next.latch[cur_idx] = cur_word;
            end
            else if (write_protect_i)
            begin
               state_next.fault = 1'b1;
            end
            else
            begin
               // final word loaded then row programmed
               state_next.latch[cur_idx] = cur_word;
               state_next.op = frlp_pkg::OP_PROG;
            end
         end
      end
      // Busy: bus writes dropped, the array paces each step
      else if (flash_ready_i)
      begin
         // Flash accepted the current request
         unique case (state_reg.op)
            frlp_pkg::OP_PROG:
            begin
               // at most 32 words per commit
               state_next.cnt = state_reg.cnt + 5'h01;
               // Word 31 taken ends the commit
               if (state_reg.cnt == frlp_pkg::LAST_IDX)
               begin
                  for (int i = 0; i < frlp_pkg::LATCH_COUNT; i++)
                     state_next.latch[i] = frlp_pkg::BLANK_WORD;
                  state_next.op   = frlp_pkg::OP_IDLE;
                  state_next.done = 1'b1;
               end
            end
            frlp_pkg::OP_ERASE:
            begin
               for (int i = 0; i < frlp_pkg::LATCH_COUNT; i++)
                  state_next.latch[i] = frlp_pkg::BLANK_WORD;
               state_next.op   = frlp_pkg::OP_IDLE;
               state_next.done = 1'b1;
            end
            default:
               state_next.op = frlp_pkg::OP_IDLE;
         endcase
      end
      // Read data, valid only the cycle after the strobe
      state_next.rdata = frlp_pkg::BYTE_RESET;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            frlp_pkg::ADDR_LOW_OFS:  state_next.rdata = state_reg.addr_low;
            frlp_pkg::ADDR_HIGH_OFS: state_next.rdata = state_reg.addr_high;
            frlp_pkg::DATA_LOW_OFS:  state_next.rdata = state_reg.data_low;
            frlp_pkg::DATA_HIGH_OFS: state_next.rdata = state_reg.data_high;
            // Bit 0 reads back the busy state
            frlp_pkg::CONTROL_OFS:
               state_next.rdata = {1'b0, state_reg.css, state_reg.done,
                                   state_reg.fault, state_reg.erase,
                                   state_reg.llo, state_reg.permit, busy};
            default:
               // Unlock key and unmapped offsets read zero
               state_next.rdata = frlp_pkg::BYTE_RESET;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Synchronous reset acts even while the enable is low
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         // Bus registers and mode bits clear
         state_reg.addr_low  <= frlp_pkg::BYTE_RESET;
         state_reg.addr_high <= frlp_pkg::BYTE_RESET;
         state_reg.data_low  <= frlp_pkg::BYTE_RESET;
         state_reg.data_high <= frlp_pkg::BYTE_RESET;
         state_reg.permit    <= 1'b0;
         state_reg.llo       <= 1'b0;
         state_reg.erase     <= 1'b0;
         state_reg.css       <= 1'b0;
         // reset during an operation leaves a fault
         state_reg.fault     <= state_reg.fault | busy;
         state_reg.done      <= 1'b0;
         state_reg.key       <= frlp_pkg::KEY_IDLE;
         state_reg.op        <= frlp_pkg::OP_IDLE;
         state_reg.cnt       <= '0;
         state_reg.row       <= '0;
         state_reg.op_css    <= 1'b0;
         state_reg.rdata     <= frlp_pkg::BYTE_RESET;
         for (int i = 0; i < frlp_pkg::LATCH_COUNT; i++)
            state_reg.latch[i] <= frlp_pkg::BLANK_WORD;
      end
      // Low clock enable freezes every field
      else if (ce_i)
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Read data stands one cycle, zero otherwise
   assign reg_rdata_o       = state_reg.rdata;
   // Request fields come straight from the state record
   assign flash_req_o.valid = busy;
   assign flash_req_o.erase = (state_reg.op == frlp_pkg::OP_ERASE);
   assign flash_req_o.cfg   = state_reg.op_css;
   // word address never leaves the captured row
   assign flash_req_o.addr  = {state_reg.row, state_reg.cnt};
   assign flash_req_o.data  = state_reg.latch[state_reg.cnt];
   assign cpu_stall_o       = busy;

endmodule : frlp_top

/* core/frlp_pkg.sv */
// Package of constants and types for the flash row latch programmer
package frlp_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_LOW_OFS   = 4'h0; // Address pair, low byte
   localparam logic [3:0] ADDR_HIGH_OFS  = 4'h1; // Address pair, high byte
   localparam logic [3:0] DATA_LOW_OFS   = 4'h2; // Data pair, low byte
   localparam logic [3:0] DATA_HIGH_OFS  = 4'h3; // Data pair, high byte
   localparam logic [3:0] CONTROL_OFS    = 4'h4; // Control and status
   localparam logic [3:0] UNLOCK_OFS     = 4'h5; // Unlock key, reads zero

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTL_TRIGGER_BIT = 0; // Program trigger, reads busy
   localparam int CTL_PERMIT_BIT  = 1; // Modify permit
   localparam int CTL_LLO_BIT     = 2; // Latch load only
   localparam int CTL_ERASE_BIT   = 3; // Row erase select
   localparam int CTL_FAULT_BIT   = 4; // Program fault flag
   localparam int CTL_DONE_BIT    = 5; // Memory done flag
   localparam int CTL_CSS_BIT     = 6; // Config space select

   // ------------------------------------------------------------
   // Key values, latch geometry, reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  KEY_FIRST     = 8'h55; // First key byte
   localparam logic [7:0]  KEY_SECOND    = 8'haa; // Second key byte
   localparam int          LATCH_COUNT   = 32;    // Latches per row
   localparam int          IDX_W         = 5;     // Latch index width
   localparam int          ROW_W         = 10;    // Row number width
   localparam int          WORD_W        = 14;    // Flash word width
   localparam logic [13:0] BLANK_WORD    = 14'h3fff; // Blank latch value
   localparam logic [7:0]  BYTE_RESET    = 8'h00; // Reset of byte registers
   localparam logic [4:0]  LAST_IDX      = 5'h1f; // Last latch index

   // ------------------------------------------------------------
   // State encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00, // No key seen
      KEY_HALF  = 2'b01, // First key byte seen
      KEY_ARMED = 2'b10  // Both key bytes seen
   } frlp_key_t;

   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00, // Nothing running
      OP_PROG  = 2'b01, // Streaming latches into the row
      OP_ERASE = 2'b10  // Erasing the row
   } frlp_op_t;

   // ------------------------------------------------------------
   // Request toward the flash array
   // ------------------------------------------------------------
   typedef struct packed {
      logic                      valid; // Request present
      logic                      erase; // 1 erase row, 0 program word
      logic                      cfg;   // Config space target
      logic [ROW_W+IDX_W-1:0]    addr;  // Row and word address
      logic [WORD_W-1:0]         data;  // Word to program
   } frlp_flash_req_t;

endpackage : frlp_pkg

/* testbench/frlp_asserts.sv */
// Port assertions for the flash row latch programmer
module frlp_asserts
(
   // Clock, reset, enable
   input wire logic                      clk_i,
   input wire logic                      nrst_i,
   input wire logic                      ce_i,
   // Register port
   input wire logic [3:0]                reg_addr_i,
   input wire logic [7:0]                reg_wdata_i,
   input wire logic                      reg_wr_i,
   input wire logic                      reg_rd_i,
   input wire logic [7:0]                reg_rdata_o,
   // Flash port and stall
   input wire frlp_pkg::frlp_flash_req_t flash_req_o,
   input wire logic                      flash_ready_i,
   input wire logic                      write_protect_i,
   input wire logic                      cpu_stall_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // First key byte taken while idle
   sequence first_s;
      ce_i && !cpu_stall_o && reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i == 8'h55;
   endsequence
   // Full key, trigger carrying erase and latch-only bits m
   sequence key_s(logic [1:0] m);
      first_s ##1 ce_i && reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i == 8'haa
      ##1 ce_i && reg_wr_i && reg_addr_i == 4'h4 && reg_wdata_i[3:0] == {m, 2'b11};
   endsequence
   load_only_a: assert property (key_s(2'b01) |=> !flash_req_o.valid [*2])
      else $error("latch load started the array");
   commit_start_a: assert property (key_s(2'b00) ##0 !write_protect_i |=> flash_req_o.valid &&
      !flash_req_o.erase && flash_req_o.addr[4:0] == 5'h00) else $error("commit did not start at word 0");
   erase_start_a: assert property (key_s(2'b10) ##0 !write_protect_i |=> flash_req_o.valid && flash_req_o.erase)
      else $error("erase did not start");
   protect_block_a: assert property (key_s(2'b00) ##0 write_protect_i |=> !flash_req_o.valid [*2])
      else $error("protected row was programmed");
   key_abort_a: assert property (first_s ##1 (ce_i && reg_rd_i) |=> !flash_req_o.valid [*3])
      else $error("broken key started an operation");
   word_step_a: assert property (flash_req_o.valid && !flash_req_o.erase && flash_ready_i && ce_i
      && flash_req_o.addr[4:0] != 5'h1f |=> flash_req_o.valid && flash_req_o.addr == $past(flash_req_o.addr) + 15'h1)
      else $error("program left its row or skipped a word");
   row_end_a: assert property (flash_req_o.valid && !flash_req_o.erase && flash_ready_i && ce_i
      && flash_req_o.addr[4:0] == 5'h1f |=> !flash_req_o.valid) else $error("program ran past 32 words");
   erase_once_a: assert property (flash_req_o.valid && flash_req_o.erase && flash_ready_i && ce_i
      |=> !flash_req_o.valid) else $error("erase ran beyond one row");
   hold_req_a: assert property (flash_req_o.valid && !flash_ready_i |=> $stable(flash_req_o))
      else $error("request changed before acceptance");
   stall_run_a: assert property (cpu_stall_o == flash_req_o.valid)
      else $error("stall does not match running operation");
   unlock_zero_a: assert property (ce_i && reg_rd_i && reg_addr_i == 4'h5 |=> reg_rdata_o == 8'h00)
      else $error("unlock register read nonzero");
   freeze_hold_a: assert property (!ce_i |=> $stable(flash_req_o) && $stable(reg_rdata_o))
      else $error("state moved while clock enable was low");
endmodule : frlp_asserts

bind frlp_top frlp_asserts i_chk (.clk_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .flash_req_o, .flash_ready_i, .write_protect_i, .cpu_stall_o);

/* testbench/frlp_top_test.sv */
// Self-checking bench for the flash row latch programmer
module frlp_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0]                reg_addr_i = 4'h0;
   logic [7:0]                reg_wdata_i = 8'h00, reg_rdata_o;
   logic                      flash_ready_i = 1'b0, write_protect_i = 1'b0, cpu_stall_o;
   frlp_pkg::frlp_flash_req_t flash_req_o;
   logic [13:0]               lat [32]; // Expected latch contents
   logic [9:0]                row;      // Row under test
   logic                      cfg = 1'b0; // Expected config select
   int                        fail_count = 0, compares = 0, wcnt = 0, ecnt = 0;

   always #5 clk_i = ~clk_i;

   frlp_top i_dut (.clk_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .flash_req_o, .flash_ready_i, .write_protect_i, .cpu_stall_o);

   // Value compare
   task chk(input logic [19:0] got, input logic [19:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Verdict and end of run
   task end_sim();
      if (fail_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   // Register write, strobe left high for back to back use
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_wr_i <= 1'b1;
      reg_rd_i <= 1'b0;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
   endtask : wr

   // Register read, data masked by m compared with e
   task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_rd_i <= 1'b1;
      reg_wr_i <= 1'b0;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(20'(reg_rdata_o & m), 20'(e));
   endtask : rd

   // Unlock bytes then control write c
   task key(input logic [7:0] c);
      wr(4'h5, 8'h55);
      wr(4'h5, 8'haa);
      wr(4'h4, c);
      reg_wr_i <= 1'b0;
      #1;
   endtask : key

   // Address low byte for a row and latch index
   function automatic logic [7:0] adr_lo(input logic [9:0] r, input logic [4:0] i);
      return {r[2:0], i};
   endfunction : adr_lo

   // Address, data, key; model latch follows
   task ld(input logic [4:0] i, input logic [13:0] w, input logic [7:0] c);
      wr(4'h0, adr_lo(row, i));
      wr(4'h1, {1'b0, row[9:3]});
      wr(4'h2, w[7:0]);
      wr(4'h3, {2'b00, w[13:8]});
      key(c);
      lat[i] = w;
   endtask : ld

   // Wait out a running operation
   task wait_idle();
      for (int n = 0; n < 300 && cpu_stall_o === 1'b1; n++)
      begin
         @(posedge clk_i);
         #1;
      end
      chk(20'(cpu_stall_o), 20'h0);
   endtask : wait_idle

   // Model latches back to blank
   task blank();
      foreach (lat[k]) lat[k] = frlp_pkg::BLANK_WORD;
   endtask : blank

   // Flash side accepts at random
   always @(posedge clk_i) flash_ready_i <= ($urandom % 4) != 0;

   // Each handover checked for its row; program words also against the latch model
   always @(posedge clk_i)
      if (nrst_i && ce_i && flash_req_o.valid && flash_ready_i)
      begin
         chk(20'(flash_req_o.addr[14:5]), 20'(row));
         if (flash_req_o.erase)
            ecnt++;
         else
         begin
            chk({flash_req_o.cfg, flash_req_o.addr[4:0], flash_req_o.data}, {cfg, wcnt[4:0], lat[wcnt[4:0]]});
            wcnt++;
         end
      end

   // Hang guard, well past the expected run
   initial
   begin
      #200us;
      fail_count++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'hf943));
      blank();
      row = 10'h000;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int a = 0; a < 16; a++)
         if (a != 4) rd(a[3:0], 8'hff, 8'h00);
      wr(4'h9, 8'hff);
      wr(4'h4, 8'h00);
      rd(4'h9, 8'hff, 8'h00);
      rd(4'h4, 8'hff, 8'h00);
      // Random rows: scattered latch loads, then a commit
      for (int t = 0; t < 6; t++)
      begin
         row = 10'($urandom);
         for (int i = 0; i < 31; i++)
            if ($urandom % 3 == 0)
            begin
               write_protect_i <= 1'($urandom);
               ld(i[4:0], 14'($urandom), 8'h07);
               chk(20'(cpu_stall_o), 20'h0);
            end
         write_protect_i <= 1'b0;
         wcnt = 0;
         // one commit goes to config space
         cfg = (t == 2);
         ld(t == 0 ? 5'h1f : 5'($urandom), 14'($urandom), t == 2 ? 8'h43 : 8'h03);
         chk(20'(cpu_stall_o), 20'h1);
         if (t == 1)
         begin
            // Low clock enable freezes the request at word 0
            ce_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            ce_i <= 1'b1;
            #1 chk(20'(flash_req_o.addr), 20'({row, 5'h00}));
         end
         wait_idle();
         chk(20'(wcnt), 20'd32);
         rd(4'h4, 8'h36, 8'h22);
         blank();
      end
      // Loaded latch must come back blank after an erase
      ld(5'h04, 14'h1234, 8'h07);
      ecnt = 0;
      key(8'h0b);
      wait_idle();
      chk(20'(ecnt), 20'h1);
      blank();
      wcnt = 0;
      ld(5'h00, 14'h0abc, 8'h03);
      wait_idle();
      blank();
      // Broken key, then protected row: nothing starts, fault raised
      wr(4'h5, 8'h55);
      rd(4'h0, 8'hff, adr_lo(row, 5'h00));
      rd(4'h4, 8'h10, 8'h10);
      wr(4'h5, 8'haa);
      wr(4'h4, 8'h03);
      reg_wr_i <= 1'b0;
      #1 chk(20'(cpu_stall_o), 20'h0);
      write_protect_i <= 1'b1;
      key(8'h03);
      chk(20'(cpu_stall_o), 20'h0);
      rd(4'h4, 8'h10, 8'h10);
      // Reset in mid-commit leaves the fault flag set
      write_protect_i <= 1'b0;
      wcnt = 0;
      ld(5'h02, 14'h0155, 8'h03);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      blank();
      rd(4'h4, 8'h3f, 8'h10);
      end_sim();
   end
endmodule : frlp_top_test
